// *** include/srsr_regs.vh ***
// Register map, field defaults and timing constants of the speed reference ramp block
`ifndef SRSR_REGS_VH
`define SRSR_REGS_VH
// Byte offsets, one aligned word per register
`define SRSR_OFF_CTRL       12'h000
`define SRSR_OFF_MAXREV     12'h004
`define SRSR_OFF_OFFSET     12'h008
`define SRSR_OFF_INCHREF    12'h00C
`define SRSR_OFF_REF1       12'h010
`define SRSR_OFF_REF2       12'h014
`define SRSR_OFF_REF3       12'h018
`define SRSR_OFF_REF4       12'h01C
`define SRSR_OFF_RAMP0      12'h020
`define SRSR_OFF_INCHRAMP   12'h040
`define SRSR_OFF_RAMPCTRL   12'h044
`define SRSR_OFF_POSTRAMP   12'h048
`define SRSR_OFF_STATUS     12'h04C
`define SRSR_OFF_PRERAMP    12'h050
// Control register bit positions
`define SRSR_CTRL_BIPOLAR   0
`define SRSR_CTRL_RUN       1
`define SRSR_CTRL_REVERSE   2
`define SRSR_CTRL_INCH      3
`define SRSR_CTRL_SEL_A     4
`define SRSR_CTRL_SEL_B     5
`define SRSR_CTRL_INTERLOCK 6
`define SRSR_CTRL_LOGIC_DIS 7
// Ramp control bit positions
`define SRSR_RC_ENABLE      0
`define SRSR_RC_HOLD        1
`define SRSR_RC_INCH_EN     2
`define SRSR_RC_QSEL        3
`define SRSR_RC_COMMON      7
`define SRSR_RC_X10         8
// Reset values
`define SRSR_RST_MAXREV     11'h000
`define SRSR_RST_INCHREF    11'h032
`define SRSR_RST_REF2       11'h12C
`define SRSR_RST_RAMP_G1    11'h064
`define SRSR_RST_RAMP_G2    11'h064
`define SRSR_RST_INCHRAMP   11'h064
// Scaling
`define SRSR_FULL_SCALE     11'h3E8
`define SRSR_ZERO_BAND      11'h008
`define SRSR_RAMP_MAX       11'h7CF
`define SRSR_TICK_US        100
`define SRSR_CLK_MHZ        20
`define SRSR_TICK_CYCLES    (`SRSR_TICK_US * `SRSR_CLK_MHZ)
// One ramp unit is 0.1 s, i.e. 1000 ticks of 100 us
`define SRSR_TICKS_PER_UNIT 1000
`endif

// *** rtl/srsr_speed_ref.v ***
// Speed reference selection, limiting and quadrant ramp generator with APB access
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "srsr_regs.vh"

module srsr_speed_ref (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Drive inputs
    input  wire        run_permit_input,
    input  wire        run_request_input,
    // Speed references arriving from programmable inputs
    input  wire [10:0] general_input_three,
    input  wire [10:0] general_input_four,
    input  wire        gp_ref_load,
    // Speed loop side
    output reg  [10:0] post_ramp_ref,
    output reg         start_inhibit
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_STEP = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte offsets, one aligned word each
    // 0x00 control: b0 bipolar, b1 run, b2 reverse, b3 inch,
    //      b4 select A, b5 select B, b6 zero interlock, b7 start logic off
    // 0x04 maximum reverse speed, a magnitude of 0..1000
    // 0x08 offset and 0x0C inch reference, both signed
    // 0x10..0x1C references one to four, signed
    // 0x20..0x3C ramp times, index group*4 + quadrant
    //      quadrant 0 fwd accel, 1 fwd decel, 2 rev decel, 3 rev accel
    // 0x40 inch ramp time
    // 0x44 ramp control: b0 enable, b1 hold, b2 inch ramp enable,
    //      b3..b6 per-quadrant group, b7 common group, b8 time x10
    // 0x48 post-ramp and 0x50 pre-ramp reference, read only
    // 0x4C status, read only: b0 run, b1 permit, b2 start inhibit
    // Other addresses read zero with pslverr and drop writes, except unaligned ones in 0x10..0x1C and 0x20..0x3F, which alias a word.
    // Signed values sit in the low 11 bits and read back sign-extended.
    // Reset: ramp on in group 1, all ramp times 100 (10 s), inch reference 50,
    // reference two 300, other references, offset and reverse limit zero.
    // A zero reverse limit gives two-quadrant behaviour, fwd accel and fwd decel only, until software opens it.
    // Every transfer is zero-wait: pready rises in the first access cycle.

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [7:0]  ctrl;
    reg  [10:0] max_reverse_speed;
    reg  [10:0] offset_ref;
    reg  [10:0] inch_ref;
    reg  [10:0] speed_ref [0:3];
    reg  [10:0] ramp_time [0:7];
    reg  [10:0] inch_ramp_time;
    reg  [8:0]  ramp_ctrl;
    reg  [10:0] pre_ramp_ref;
    reg  [2:0]  state;
    reg  [10:0] tick_cnt;
    reg  [31:0] acc;
    reg  [31:0] period;
    reg  [10:0] pre_offset_ref;

    wire        wr_en = psel & penable & pwrite;
    wire        permit = run_permit_input;

    // Saturate a 13-bit signed value to +/- full scale
    function [10:0] sat;
        input signed [12:0] v;
        begin
            if (v > $signed({2'b00, `SRSR_FULL_SCALE}))
                sat = `SRSR_FULL_SCALE;
            else if (v < -$signed({2'b00, `SRSR_FULL_SCALE}))
                sat = -`SRSR_FULL_SCALE;
            else
                sat = v[10:0];
        end
    endfunction

    // Ramp times run 0..1999 units; only the low 11 bits of a write are kept, and values above 1999 there are clipped, not wrapped
    function [10:0] ramp_clip;
        input [10:0] t;
        begin
            if (t > `SRSR_RAMP_MAX)
                ramp_clip = `SRSR_RAMP_MAX;
            else
                ramp_clip = t;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reference chain, evaluated combinationally
    reg  [10:0] sel_ref;
    reg  [10:0] post_off;
    reg  [10:0] polar;
    reg  [10:0] limited;
    reg  [10:0] next_pre_ramp;
    always @* begin
        sel_ref = speed_ref[{ctrl[`SRSR_CTRL_SEL_B], ctrl[`SRSR_CTRL_SEL_A]}];
        // Inch replaces every source, including references fed from inputs
        if (ctrl[`SRSR_CTRL_INCH])
            sel_ref = inch_ref;
        // Stage order matters: offset, polarity, reverse, then the reverse limit
        post_off = sat($signed({{2{sel_ref[10]}}, sel_ref}) + $signed({{2{offset_ref[10]}}, offset_ref}));
        polar = post_off;
        if (!ctrl[`SRSR_CTRL_BIPOLAR] && post_off[10])
            polar = 11'h000;
        if (ctrl[`SRSR_CTRL_REVERSE])
            polar = sat(-$signed({{2{polar[10]}}, polar}));
        limited = polar;
        if (polar[10] && ($signed(polar) < -$signed({1'b0, max_reverse_speed[9:0]})))
            limited = -{1'b0, max_reverse_speed[9:0]};
        next_pre_ramp = ctrl[`SRSR_CTRL_RUN] ? limited : 11'h000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quadrant choice and ramp period
    reg  [1:0]  quad;
    reg         grp;
    reg  [10:0] sel_time;
    reg  [31:0] next_period;
    // A zero output takes its sign from the target, so a start from rest
    // picks the accel rate of the direction it is heading
    wire        out_neg = post_ramp_ref[10] | (post_ramp_ref == 11'h000 && pre_ramp_ref[10]);
    wire        target_gt = $signed(pre_ramp_ref) > $signed(post_ramp_ref);
    always @* begin
        // Quadrant order: fwd accel, fwd decel, rev decel, rev accel
        if (!out_neg)
            quad = target_gt ? 2'd0 : 2'd1;
        else
            quad = target_gt ? 2'd2 : 2'd3;
        grp = ramp_ctrl[`SRSR_RC_COMMON] | ramp_ctrl[`SRSR_RC_QSEL + quad];
        sel_time = ramp_time[{grp, quad}];
        if (ctrl[`SRSR_CTRL_INCH] && ramp_ctrl[`SRSR_RC_INCH_EN])
            sel_time = inch_ramp_time;
        // Ticks per count: time * 1000 ticks / 1000 counts; x10 scales time
        next_period = {21'h0, sel_time};
        if (ramp_ctrl[`SRSR_RC_X10])
            next_period = {21'h0, sel_time} * 32'd10;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and run flag control
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl              <= 8'h00;
            max_reverse_speed <= `SRSR_RST_MAXREV;
            offset_ref        <= 11'h000;
            inch_ref          <= `SRSR_RST_INCHREF;
            speed_ref[0]      <= 11'h000;
            speed_ref[1]      <= `SRSR_RST_REF2;
            speed_ref[2]      <= 11'h000;
            speed_ref[3]      <= 11'h000;
            for (i = 0; i < 4; i = i + 1) begin
                ramp_time[i]   <= `SRSR_RST_RAMP_G1;
                ramp_time[i+4] <= `SRSR_RST_RAMP_G2;
            end
            inch_ramp_time    <= `SRSR_RST_INCHRAMP;
            ramp_ctrl         <= 9'h001;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `SRSR_OFF_CTRL: begin
                        ctrl <= pwdata[7:0];
                        // A refused run bit is stored as zero; the rest of the word lands
                        if (!permit)
                            ctrl[`SRSR_CTRL_RUN] <= 1'b0;
                    end
                    `SRSR_OFF_MAXREV: begin
                        // Magnitude above full scale would wrap in the 10-bit compare
                        if (pwdata[10:0] > `SRSR_FULL_SCALE)
                            max_reverse_speed <= `SRSR_FULL_SCALE;
                        else
                            max_reverse_speed <= pwdata[10:0];
                    end
                    `SRSR_OFF_OFFSET:   offset_ref <= sat({{2{pwdata[10]}}, pwdata[10:0]});
                    `SRSR_OFF_INCHREF:  inch_ref <= sat({{2{pwdata[10]}}, pwdata[10:0]});
                    `SRSR_OFF_INCHRAMP: inch_ramp_time <= ramp_clip(pwdata[10:0]);
                    `SRSR_OFF_RAMPCTRL: ramp_ctrl <= pwdata[8:0];
                    default: begin
                        if (paddr >= `SRSR_OFF_REF1 && paddr <= `SRSR_OFF_REF4)
                            speed_ref[paddr[3:2]] <= sat({{2{pwdata[10]}}, pwdata[10:0]});
                        if (paddr >= `SRSR_OFF_RAMP0 && paddr < `SRSR_OFF_INCHRAMP)
                            ramp_time[paddr[4:2]] <= ramp_clip(pwdata[10:0]);
                    end
                endcase
            end
            // Programmable inputs feed references 3 and 4
            // Level-sensitive: while the load stands, the inputs overwrite bus writes
            if (gp_ref_load) begin
                speed_ref[2] <= sat({{2{general_input_three[10]}}, general_input_three});
                speed_ref[3] <= sat({{2{general_input_four[10]}}, general_input_four});
            end
            // Start logic off: the run input is followed every cycle except a control write
            if (ctrl[`SRSR_CTRL_LOGIC_DIS] && !(wr_en && paddr == `SRSR_OFF_CTRL))
                ctrl[`SRSR_CTRL_RUN] <= run_request_input & permit;
            // Permit loss is placed last so it overrides every other source
            if (!permit)
                ctrl[`SRSR_CTRL_RUN] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ramp engine: one step per tick, period counted in ticks
    // A tick is 2000 cycles, 100 us at 20 MHz. A ramp time of T units of 0.1 s
    // spans 1000 counts in 1000*T ticks, so the output moves a count every T
    // ticks, or 10*T when scaled. Except at zero time, which jumps straight to the target, the step is one whole count, so long
    // ramps move in visible stairs rather than fractions.
    // The quadrant is chosen afresh on each step, so a target across zero
    // switches from the decel to the accel rate as the output passes zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            tick_cnt       <= 11'h000;
            acc            <= 32'h0;
            period         <= 32'h0;
            pre_ramp_ref   <= 11'h000;
            post_ramp_ref  <= 11'h000;
            pre_offset_ref <= 11'h000;
            start_inhibit  <= 1'b0;
        end else begin
            pre_ramp_ref   <= next_pre_ramp;
            pre_offset_ref <= sel_ref;
            period         <= next_period;
            // Start held off until reference is near zero
            // The interlock only reports; the start logic elsewhere must honour it.
            // Inch counts as a source, so an inch reference outside the band inhibits too.
            start_inhibit  <= ctrl[`SRSR_CTRL_INTERLOCK] & ~ctrl[`SRSR_CTRL_RUN] &
                              ~(($signed(sel_ref) > -$signed(`SRSR_ZERO_BAND)) &&
                                ($signed(sel_ref) < $signed(`SRSR_ZERO_BAND)));
            case (state)
                ST_IDLE: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    // STEP takes a cycle itself, so WAIT ends one early: 2000 cycles a tick
                    if (tick_cnt == `SRSR_TICK_CYCLES - 2) begin
                        tick_cnt <= 11'h000;
                        state    <= ST_STEP;
                    end else begin
                        tick_cnt <= tick_cnt + 11'h001;
                    end
                end
                ST_STEP: begin
                    state <= ST_WAIT;
                    if (!ramp_ctrl[`SRSR_RC_ENABLE]) begin
                        post_ramp_ref <= pre_ramp_ref;
                        acc <= 32'h0;
                    end else if (ramp_ctrl[`SRSR_RC_HOLD]) begin
                        // Hold keeps the part count too, so release resumes mid-count
                        acc <= acc;
                    end else if (post_ramp_ref != pre_ramp_ref) begin
                        // Zero time means instant step; else one count per period ticks
                        if (period == 32'h0 || acc + 32'd1 >= period) begin
                            acc <= 32'h0;
                            post_ramp_ref <= target_gt ? post_ramp_ref + 11'h001
                                                       : post_ramp_ref - 11'h001;
                            if (period == 32'h0)
                                post_ramp_ref <= pre_ramp_ref;
                        end else begin
                            acc <= acc + 32'd1;
                        end
                    end else begin
                        acc <= 32'h0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Bypass is immediate, not tick-paced
            if (!ramp_ctrl[`SRSR_RC_ENABLE])
                post_ramp_ref <= pre_ramp_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read path; zero-wait, unmapped reads give zero with pslverr
    // Read data is latched in setup so it stands through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel & ~penable) begin
                case (paddr)
                    `SRSR_OFF_CTRL:     prdata <= {24'h0, ctrl};
                    `SRSR_OFF_MAXREV:   prdata <= {21'h0, max_reverse_speed};
                    `SRSR_OFF_OFFSET:   prdata <= {{21{offset_ref[10]}}, offset_ref};
                    `SRSR_OFF_INCHREF:  prdata <= {{21{inch_ref[10]}}, inch_ref};
                    `SRSR_OFF_INCHRAMP: prdata <= {21'h0, inch_ramp_time};
                    `SRSR_OFF_RAMPCTRL: prdata <= {23'h0, ramp_ctrl};
                    `SRSR_OFF_POSTRAMP: prdata <= {{21{post_ramp_ref[10]}}, post_ramp_ref};
                    `SRSR_OFF_STATUS:   prdata <= {29'h0, start_inhibit, permit, ctrl[`SRSR_CTRL_RUN]};
                    `SRSR_OFF_PRERAMP:  prdata <= {{21{pre_ramp_ref[10]}}, pre_ramp_ref};
                    default: begin
                        if (paddr >= `SRSR_OFF_REF1 && paddr <= `SRSR_OFF_REF4)
                            prdata <= {{21{speed_ref[paddr[3:2]][10]}}, speed_ref[paddr[3:2]]};
                        else if (paddr >= `SRSR_OFF_RAMP0 && paddr < `SRSR_OFF_INCHRAMP)
                            prdata <= {21'h0, ramp_time[paddr[4:2]]};
                        else
                            pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // srsr_speed_ref
`default_nettype wire

// *** test/srsr_speed_ref_chk.sv ***
// Port-level assertions for the speed reference ramp block
`timescale 1ns/1ns
`default_nettype none
module srsr_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Drive side
    input wire logic        run_permit_input,
    input wire logic        run_request_input,
    input wire logic        gp_ref_load,
    input wire logic [10:0] post_ramp_ref,
    input wire logic        start_inhibit
);
    ////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Last cycle's run input, so that only a change of it counts as a cause
    logic prev_request;
    always_ff @(posedge pclk) prev_request <= run_request_input;
    // Anything that can move the selected reference or drop the run flag
    wire cause = (psel && penable && pwrite) || gp_ref_load || !run_permit_input ||
                 (run_request_input != prev_request);

    // Bus answer timing
    a_ready_setup: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer in first access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_no_select: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_err_unmapped: assert property (pready && paddr > 12'h050 |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (pready && !pwrite && paddr <= 12'h050 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped read flagged as error");
    // Values and interlock
    a_post_range: assert property ($signed(post_ramp_ref) >= -1000 && $signed(post_ramp_ref) <= 1000)
        else $error("post-ramp reference beyond full scale");
    a_inhibit_cause: assert property ($rose(start_inhibit) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("inhibit rose without a cause");
endmodule // srsr_chk

bind srsr_speed_ref srsr_chk srsr_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .run_permit_input, .run_request_input, .gp_ref_load, .post_ramp_ref, .start_inhibit);
`default_nettype wire

// *** test/srsr_drive_side.sv ***
// Far-side model: run permit, run request and programmable reference inputs
`timescale 1ns/1ns
`default_nettype none
module srsr_drive_side (
    // Clock
    input  wire logic        pclk,
    // Drive inputs
    output var  logic        run_permit_input,
    output var  logic        run_request_input,
    output var  logic [10:0] general_input_three,
    output var  logic [10:0] general_input_four,
    output var  logic        gp_ref_load
);
    // Start with permit absent so no run can be latched early
    initial begin
        {run_permit_input, run_request_input, gp_ref_load} = 3'h0;
        {general_input_three, general_input_four} = 22'h0;
    end
    // Terminal levels change just after an edge and then stand; two edges pass
    // so the run flag and the pre-ramp register have settled before any read
    task automatic set(input logic p, r, l, input logic [10:0] a, b);
        @(posedge pclk);
        {run_permit_input, run_request_input, gp_ref_load, general_input_three, general_input_four} <= {p, r, l, a, b};
        repeat (2) @(posedge pclk);
    endtask
endmodule // srsr_drive_side
`default_nettype wire

// *** test/srsr_testbench.sv ***
// Self-checking bench for the speed reference ramp block
`timescale 1ns/1ns
`default_nettype none
`include "srsr_regs.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, start_inhibit;
    logic        run_permit_input, run_request_input, gp_ref_load;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [10:0] general_input_three, general_input_four, post_ramp_ref;
    int          n_errors = 0;
    int          comparisons = 0;
    int          rv[4] = '{100, -200, 300, -400};

    srsr_speed_ref srsr_speed_ref_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .run_permit_input, .run_request_input, .general_input_three, .general_input_four,
        .gp_ref_load, .post_ramp_ref, .start_inhibit);
    srsr_drive_side srsr_drive_side_inst (.pclk, .run_permit_input, .run_request_input, .general_input_three,
        .general_input_four, .gp_ref_load);

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; a missing answer is counted rather than hung on
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_errors++;
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xf(1'b1, a, d);
    endtask
    task automatic ex(input logic [11:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Ramp bypassed: both the pre-ramp register and the output must match
    task automatic pe(input logic [31:0] e);
        ex(`SRSR_OFF_PRERAMP, e);
        chk(32'($signed(post_ramp_ref)), e);
    endtask
    task automatic ilk(input logic [31:0] v, input logic e);
        wr(`SRSR_OFF_REF1, v);
        repeat (2) @(posedge pclk);
        chk(start_inhibit, e);
    endtask
    // Four ticks of ramping; movement must fall inside lo..hi counts
    task automatic win(input logic [31:0] rc, input int lo, hi);
        int v;
        wr(`SRSR_OFF_RAMPCTRL, rc);
        v = $signed(post_ramp_ref);
        repeat (8000) @(posedge pclk);
        v = $signed(post_ramp_ref) - v;
        chk(v >= lo && v <= hi, 1'b1);
    endtask
    task report_and_stop;
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Whole run is about 75k cycles; cut off at 100k
    initial begin
        #5000000;
        n_errors++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ex(`SRSR_OFF_RAMPCTRL, 32'h001);
        ex(`SRSR_OFF_REF2, 32'h12C);
        ex(`SRSR_OFF_CTRL, 32'h0);
        ex(`SRSR_OFF_MAXREV, 32'h0);
        xf(1'b0, 12'h100, 32'h0);
        chk(err, 1'b1);
        wr(`SRSR_OFF_CTRL, 32'h3);
        ex(`SRSR_OFF_CTRL, 32'h1);
        srsr_drive_side_inst.set(1, 0, 0, 0, 0);
        wr(`SRSR_OFF_RAMPCTRL, 32'h0);
        wr(`SRSR_OFF_MAXREV, 1000);
        for (int i = 0; i < 4; i++) wr(12'(`SRSR_OFF_REF1 + 4 * i), rv[i]);
        for (int i = 0; i < 4; i++) begin
            wr(`SRSR_OFF_CTRL, 32'(3 | i << 4));
            pe(rv[i]);
        end
        wr(`SRSR_OFF_CTRL, 32'h3);
        wr(`SRSR_OFF_OFFSET, 50);
        pe(150);
        wr(`SRSR_OFF_OFFSET, 950);
        pe(1000);
        wr(`SRSR_OFF_OFFSET, -150);
        wr(`SRSR_OFF_CTRL, 32'h2);
        pe(0);
        wr(`SRSR_OFF_OFFSET, 0);
        wr(`SRSR_OFF_CTRL, 32'h7);
        pe(-100);
        wr(`SRSR_OFF_CTRL, 32'h33);
        wr(`SRSR_OFF_MAXREV, 150);
        pe(-150);
        wr(`SRSR_OFF_MAXREV, 0);
        pe(0);
        wr(`SRSR_OFF_MAXREV, 1000);
        wr(`SRSR_OFF_CTRL, 32'h0B);
        pe(50);
        wr(`SRSR_OFF_CTRL, 32'h1);
        pe(0);
        wr(`SRSR_OFF_CTRL, 32'h3);
        ex(`SRSR_OFF_STATUS, 32'h3);
        srsr_drive_side_inst.set(0, 0, 0, 0, 0);
        pe(0);
        srsr_drive_side_inst.set(1, 0, 0, 0, 0);
        ex(`SRSR_OFF_CTRL, 32'h1);
        wr(`SRSR_OFF_CTRL, 32'h81);
        srsr_drive_side_inst.set(1, 1, 0, 0, 0);
        ex(`SRSR_OFF_STATUS, 32'h3);
        srsr_drive_side_inst.set(0, 1, 0, 0, 0);
        ex(`SRSR_OFF_STATUS, 32'h0);
        srsr_drive_side_inst.set(1, 0, 1, 11'h0FA, 11'h706);
        wr(`SRSR_OFF_CTRL, 32'h23);
        pe(250);
        wr(`SRSR_OFF_CTRL, 32'h33);
        pe(-250);
        srsr_drive_side_inst.set(1, 0, 0, 0, 0);
        // Interlock band is open at both ends: 8 inhibits, 7 does not
        wr(`SRSR_OFF_CTRL, 32'h41);
        ilk(8, 1'b1);
        ilk(7, 1'b0);
        ilk(-8, 1'b1);
        ilk(-7, 1'b0);
        // Ramp from rest toward full scale with one tick per count in group 1
        wr(`SRSR_OFF_REF1, 0);
        wr(`SRSR_OFF_CTRL, 32'h3);
        for (int i = 0; i < 4; i++) wr(12'(`SRSR_OFF_RAMP0 + 4 * i), 1);
        wr(`SRSR_OFF_RAMPCTRL, 32'h001);
        wr(`SRSR_OFF_REF1, 1000);
        win(32'h001, 3, 5);
        win(32'h079, 0, 1);
        win(32'h081, 0, 1);
        win(32'h101, 0, 1);
        win(32'h003, 0, 0);
        wr(`SRSR_OFF_RAMPCTRL, 32'h002);
        pe(1000);
        // Inch ramp against slow group 2; then fwd decel alone in group 1
        wr(`SRSR_OFF_INCHRAMP, 1);
        wr(`SRSR_OFF_RAMPCTRL, 32'h087);
        wr(`SRSR_OFF_CTRL, 32'h0B);
        win(32'h085, -5, -3);
        win(32'h069, -5, -3);
        // Reverse side: rev decel, then rev accel, each alone in group 1
        wr(`SRSR_OFF_RAMPCTRL, 32'h0);
        wr(`SRSR_OFF_CTRL, 32'h3);
        wr(`SRSR_OFF_REF1, -500);
        pe(-500);
        wr(`SRSR_OFF_RAMPCTRL, 32'h05B);
        wr(`SRSR_OFF_REF1, 0);
        win(32'h059, 3, 5);
        wr(`SRSR_OFF_REF1, -1000);
        win(32'h039, -5, -3);
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
